// >>> design/lcr_config_regs.sv
// Configuration register bank of a video link retimer: receiver and mode
// control, output driver control, swing and de-emphasis, fixed EQ levels.
// Assumes a byte register port driven by the serial host engine, all
// inputs synchronous to clk, and lane circuitry outside this block.
//
// Summary of operation
// - Placement bit picks source or sink EQ centre
// - Gate bit blocks sink-to-source hot-plug forwarding
// - Adapt bit fixed/adaptive; writes ignored in strap mode
// - Equalizer enable bit turns receive equalizer on
// - Lane fields staged until apply bit written
// - Settings apply directly when output, hot-plug, power idle
// - Function mode selects redriver, auto or retimer
// - Slew field fastest to slowest; strap blocks writes
// - Protocol bit picks output format; strap blocks writes
// - Termination field none or 150-300 ohm
// - Data swing field raises or lowers swing
// - Clock swing same coding, overrides rate default
// - De-emphasis field none or 2 dB
// - Data lane fixed EQ eight levels
// - Clock lane fixed EQ three levels
// - Reserved read-only bits read zero, ignore writes
`timescale 1ns/1ns
module lcr_config_regs (
  input  logic                  clk,
  input  logic                  srst,
  // Register port from the serial host engine
  input  lcr_pkg::lcr_reg_req_s regReq,
  output logic [7:0]            regRdData,
  output logic                  regRdValid,
  // Device pins and neighbouring state
  input  logic                  strapCfgSel,
  input  logic                  outputEnable,
  input  logic                  sinkHotplugIn,
  input  logic                  hostPowerDown,
  output logic                  sourceHotplugOut,
  // Settings toward the lane circuitry
  output logic                  sinkPlacement,
  output lcr_pkg::lcr_func_mode_e functionMode,
  output logic                  outputProtocolAlt,
  output lcr_pkg::lcr_lane_cfg_s laneCfg
);

  // Registered state, plus the combinational next staged word
  lcr_pkg::lcr_lane_cfg_s stagedCfg_r;
  lcr_pkg::lcr_lane_cfg_s stagedCfg_nxt;
  logic                   placement_r;
  logic                   hpBlock_r;
  logic                   rsvRxMode_r;
  logic [1:0]             mode_r;
  logic                   proto_r;
  logic [1:0]             rsvEqHi_r;
  logic                   rsvEqLo_r;
  logic [7:0]             rdData_r;
  logic                   rdValid_r;

  // Decoded accesses
  logic [7:0] wd;
  logic       wrRxMode;
  logic       wrDriver;
  logic       wrSwing;
  logic       wrEqLev;
  logic       hostOwnsStrap;
  logic       applyReq;
  logic       directLoad;
  logic       laneLoad;

  // Next values of staged fields
  logic [1:0] slewNxt;
  logic [1:0] termNxt;
  logic [1:0] deemphNxt;
  logic       eqEnNxt;
  logic       adaptNxt;
  logic [2:0] dSwingNxt;
  logic [2:0] cSwingNxt;
  logic [2:0] dEqNxt;
  logic [1:0] cEqNxt;

  // Read-back words
  logic [7:0] rdRxMode;
  logic [7:0] rdDriver;
  logic [7:0] rdSwing;
  logic [7:0] rdEqLev;
  logic [7:0] rdMux;

  // Address decode of write requests
  assign wd       = regReq.wrData;
  assign wrRxMode = regReq.wrEn && (regReq.addr == lcr_pkg::ADDR_RX_MODE);
  assign wrDriver = regReq.wrEn && (regReq.addr == lcr_pkg::ADDR_DRIVER);
  assign wrSwing  = regReq.wrEn && (regReq.addr == lcr_pkg::ADDR_SWING);
  assign wrEqLev  = regReq.wrEn && (regReq.addr == lcr_pkg::ADDR_EQ_LEV);
  assign hostOwnsStrap = strapCfgSel;  // 0 means pins own the fields

  // Staged field updates, strap-owned fields locked in pin mode
  assign adaptNxt  = (wrRxMode && hostOwnsStrap) ?
                     wd[lcr_pkg::ADAPT_BIT] : stagedCfg_r.eqAdapt;
  assign eqEnNxt   = wrRxMode ?
                     wd[lcr_pkg::EQEN_BIT] : stagedCfg_r.eqEn;
  assign slewNxt   = (wrDriver && hostOwnsStrap) ?
                     wd[lcr_pkg::SLEW_LSB +: 2] : stagedCfg_r.slew;
  assign termNxt   = wrDriver ?
                     wd[lcr_pkg::TERM_LSB +: 2] : stagedCfg_r.term;
  assign dSwingNxt = wrSwing ?
                     wd[lcr_pkg::DSWING_LSB +: 3] :
                     stagedCfg_r.dataSwing;
  assign cSwingNxt = wrSwing ?
                     wd[lcr_pkg::CSWING_LSB +: 3] :
                     stagedCfg_r.clkSwing;
  assign deemphNxt = wrSwing ?
                     wd[lcr_pkg::DEEMPH_LSB +: 2] :
                     stagedCfg_r.deemph;
  assign dEqNxt    = wrEqLev ?
                     wd[lcr_pkg::DEQ_LSB +: 3] : stagedCfg_r.dataEq;
  assign cEqNxt    = wrEqLev ?
                     wd[lcr_pkg::CEQ_LSB +: 2] : stagedCfg_r.clkEq;

  // Gather staged fields into one word
  assign stagedCfg_nxt = '{
    slew: slewNxt, term: termNxt, deemph: deemphNxt,
    eqEn: eqEnNxt, eqAdapt: adaptNxt, dataSwing: dSwingNxt,
    clkSwing: cSwingNxt, dataEq: dEqNxt, clkEq: cEqNxt};

  // Lane transfer: apply pulse, or idle link takes settings directly
  assign applyReq   = wrRxMode && wd[lcr_pkg::APPLY_BIT];
  assign directLoad = !outputEnable || !sinkHotplugIn
                      || hostPowerDown;
  assign laneLoad   = applyReq || directLoad;

  // Staging stage holds host writes
  always_ff @(posedge clk) begin
    if (srst) begin
      stagedCfg_r <= lcr_pkg::LANE_RST;
    end else begin
      stagedCfg_r <= stagedCfg_nxt;
    end
  end

  // Immediate fields of the receiver and mode register
  always_ff @(posedge clk) begin
    if (srst) begin
      placement_r <= lcr_pkg::RST_PLACE;
      hpBlock_r   <= lcr_pkg::RST_HPBLK;
      rsvRxMode_r <= lcr_pkg::RST_RSV;
      mode_r      <= lcr_pkg::RST_MODE;
    end else if (wrRxMode) begin
      placement_r <= wd[lcr_pkg::PLACE_BIT];
      hpBlock_r   <= wd[lcr_pkg::HPBLK_BIT];
      rsvRxMode_r <= wd[lcr_pkg::RSVA_BIT];
      mode_r      <= wd[lcr_pkg::MODE_LSB +: 2];
    end
  end

  // Output protocol select, locked while pins own it
  always_ff @(posedge clk) begin
    if (srst) begin
      proto_r <= lcr_pkg::RST_PROTO;
    end else if (wrDriver && hostOwnsStrap) begin
      proto_r <= wd[lcr_pkg::PROTO_BIT];
    end
  end

  // Writable spare bits of the equalizer level register
  always_ff @(posedge clk) begin
    if (srst) begin
      rsvEqHi_r <= {2{lcr_pkg::RST_RSV}};
      rsvEqLo_r <= lcr_pkg::RST_RSV;
    end else if (wrEqLev) begin
      rsvEqHi_r <= wd[lcr_pkg::RSVD_HI_LSB +: 2];
      rsvEqLo_r <= wd[lcr_pkg::RSVD_LO_BIT];
    end
  end

  // Active lane settings, swapped as one word
  lcr_shadow_reg #(
    .W   ($bits(lcr_pkg::lcr_lane_cfg_s)),
    .RST (lcr_pkg::LANE_RST)
  ) u_shadow (
    .clk  (clk),
    .srst (srst),
    .load (laneLoad),
    .d    (stagedCfg_nxt),
    .q    (laneCfg)
  );

  // Hot-plug forwarding path
  lcr_hotplug_gate u_hpd (
    .clk              (clk),
    .srst             (srst),
    .sinkHotplugIn    (sinkHotplugIn),
    .forwardBlock     (hpBlock_r),
    .sourceHotplugOut (sourceHotplugOut)
  );

  // Read-back words; apply and read-only spares show zero
  assign rdRxMode = {placement_r, hpBlock_r, stagedCfg_r.eqAdapt,
                     stagedCfg_r.eqEn, rsvRxMode_r, 1'b0,
                     mode_r};
  assign rdDriver = {stagedCfg_r.slew, proto_r, stagedCfg_r.term,
                     3'h0};
  assign rdSwing  = {stagedCfg_r.dataSwing, stagedCfg_r.clkSwing,
                     stagedCfg_r.deemph};
  assign rdEqLev  = {rsvEqHi_r, stagedCfg_r.dataEq, stagedCfg_r.clkEq,
                     rsvEqLo_r};

  // Read select; unmapped offsets read zero
  assign rdMux =
    (regReq.addr == lcr_pkg::ADDR_RX_MODE) ? rdRxMode :
    (regReq.addr == lcr_pkg::ADDR_DRIVER)  ? rdDriver :
    (regReq.addr == lcr_pkg::ADDR_SWING)   ? rdSwing  :
    (regReq.addr == lcr_pkg::ADDR_EQ_LEV)  ? rdEqLev  : 8'h00;

  // Registered read data, one cycle after the request
  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_r  <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= regReq.rdEn;
      if (regReq.rdEn) begin
        rdData_r <= rdMux;
      end
    end
  end

  // Outputs
  assign regRdData         = rdData_r;
  assign regRdValid        = rdValid_r;
  assign sinkPlacement     = placement_r;
  assign functionMode      = lcr_pkg::lcr_func_mode_e'(mode_r);
  assign outputProtocolAlt = proto_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_rx_write;
    wrRxMode && !regReq.rdEn;
  endsequence

  sequence s_read(logic [7:0] a);
    regReq.rdEn && (regReq.addr == a);
  endsequence

  property p_placement;
    wrRxMode |=> (sinkPlacement == $past(wd[lcr_pkg::PLACE_BIT]));
  endproperty
  a_placement: assert property (p_placement)
    else $error("Placement bit not taken from write");

  property p_eqen_write;
    wrRxMode |=> (stagedCfg_r.eqEn == $past(wd[lcr_pkg::EQEN_BIT]));
  endproperty
  a_eqen_write: assert property (p_eqen_write)
    else $error("Equalizer enable not staged from write");

  property p_adapt_write;
    (wrRxMode && strapCfgSel) |=>
      (stagedCfg_r.eqAdapt == $past(wd[lcr_pkg::ADAPT_BIT]));
  endproperty
  a_adapt_write: assert property (p_adapt_write)
    else $error("Adapt bit not staged from write");

  property p_proto_write;
    (wrDriver && strapCfgSel) |=>
      (outputProtocolAlt == $past(wd[lcr_pkg::PROTO_BIT]));
  endproperty
  a_proto_write: assert property (p_proto_write)
    else $error("Protocol select not taken from write");

  property p_term_staged;
    wrDriver |=> (stagedCfg_r.term == $past(wd[lcr_pkg::TERM_LSB +: 2]));
  endproperty
  a_term_staged: assert property (p_term_staged)
    else $error("Termination not staged from write");

  property p_adapt_locked;
    (wrRxMode && !strapCfgSel) |=>
      (stagedCfg_r.eqAdapt == $past(stagedCfg_r.eqAdapt));
  endproperty
  a_adapt_locked: assert property (p_adapt_locked)
    else $error("Adapt bit changed in strap mode");

  property p_staged_only;
    (s_rx_write ##0 (!applyReq && !directLoad)) |=>
      (laneCfg.eqEn == $past(laneCfg.eqEn));
  endproperty
  a_staged_only: assert property (p_staged_only)
    else $error("Equalizer enable took effect without apply");

  property p_apply;
    applyReq |=> (laneCfg == stagedCfg_r);
  endproperty
  a_apply: assert property (p_apply)
    else $error("Apply did not move staged settings");

  property p_direct;
    directLoad |=> (laneCfg == stagedCfg_r);
  endproperty
  a_direct: assert property (p_direct)
    else $error("Idle link did not take settings directly");

  property p_mode;
    wrRxMode ##1 !wrRxMode |->
      (functionMode == $past(wd[lcr_pkg::MODE_LSB +: 2], 1));
  endproperty
  a_mode: assert property (p_mode)
    else $error("Function mode not held from write");

  property p_slew_locked;
    (wrDriver && !strapCfgSel) |=> $stable(stagedCfg_r.slew);
  endproperty
  a_slew_locked: assert property (p_slew_locked)
    else $error("Slew changed in strap mode");

  property p_proto_locked;
    (wrDriver && !strapCfgSel) |=> $stable(outputProtocolAlt);
  endproperty
  a_proto_locked: assert property (p_proto_locked)
    else $error("Protocol select changed in strap mode");

  property p_swing_readback;
    (wrSwing ##1 (s_read(lcr_pkg::ADDR_SWING) && !wrSwing)) |=>
      (regRdValid && regRdData == $past(wd, 2));
  endproperty
  a_swing_readback: assert property (p_swing_readback)
    else $error("Swing register read-back mismatch");

  property p_reserved_zero;
    s_read(lcr_pkg::ADDR_DRIVER) |=> (regRdData[2:0] == 3'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved driver bits read nonzero");

  property p_apply_reads_zero;
    s_read(lcr_pkg::ADDR_RX_MODE) |=>
      (regRdValid && !regRdData[lcr_pkg::APPLY_BIT]);
  endproperty
  a_apply_reads_zero: assert property (p_apply_reads_zero)
    else $error("Apply bit read back as one");

  property p_eqlev_readback;
    (wrEqLev ##1 (s_read(lcr_pkg::ADDR_EQ_LEV) && !wrEqLev)) |=>
      (regRdData[5:1] == $past(wd[5:1], 2));
  endproperty
  a_eqlev_readback: assert property (p_eqlev_readback)
    else $error("Equalizer level read-back mismatch");

endmodule : lcr_config_regs

// >>> design/lcr_hotplug_gate.sv
// Registered forwarding of the sink hot-plug level to the source side.
// Assumes sinkHotplugIn is already synchronous to clk.
`timescale 1ns/1ns
module lcr_hotplug_gate (
  input  logic clk,
  input  logic srst,
  input  logic sinkHotplugIn,
  input  logic forwardBlock,
  output logic sourceHotplugOut
);

  // Pass the level through unless forwarding is blocked
  always_ff @(posedge clk) begin
    if (srst) begin
      sourceHotplugOut <= 1'b0;
    end else begin
      sourceHotplugOut <= sinkHotplugIn && !forwardBlock;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_blocked;
    forwardBlock ##1 forwardBlock |-> !sourceHotplugOut;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("Hot-plug forwarded while blocked");

  property p_forward;
    !forwardBlock |=> (sourceHotplugOut == $past(sinkHotplugIn));
  endproperty
  a_forward: assert property (p_forward)
    else $error("Hot-plug level not forwarded");

endmodule : lcr_hotplug_gate

// >>> design/lcr_shadow_reg.sv
// Active copy of staged lane settings, loaded whole in one edge.
// Assumes load and d are synchronous to clk.
`timescale 1ns/1ns
module lcr_shadow_reg #(
  parameter int             W   = 19,
  parameter logic [W-1:0]   RST = '0
) (
  input  logic         clk,
  input  logic         srst,
  input  logic         load,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);

  // Whole-word load, never a mix of old and new fields
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= RST;
    end else if (load) begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_load_whole;
    load |=> (q == $past(d));
  endproperty
  a_load_whole: assert property (p_load_whole)
    else $error("Active lane word differs from loaded word");

  property p_hold;
    !load |=> $stable(q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Active lane word moved without a load");

endmodule : lcr_shadow_reg

// >>> shared/lcr_pkg.sv
// Constants and types for the link conditioner configuration bank.
// Assumes a byte-wide register port fed by the serial host engine.
package lcr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_RX_MODE = 8'h0A;
  localparam logic [7:0] ADDR_DRIVER  = 8'h0B;
  localparam logic [7:0] ADDR_SWING   = 8'h0C;
  localparam logic [7:0] ADDR_EQ_LEV  = 8'h0D;

  // Field positions, receiver and mode control
  localparam int PLACE_BIT  = 7;
  localparam int HPBLK_BIT  = 6;
  localparam int ADAPT_BIT  = 5;
  localparam int EQEN_BIT   = 4;
  localparam int RSVA_BIT   = 3;
  localparam int APPLY_BIT  = 2;
  localparam int MODE_LSB   = 0;
  // Field positions, output driver control
  localparam int SLEW_LSB   = 6;
  localparam int PROTO_BIT  = 5;
  localparam int TERM_LSB   = 3;
  // Field positions, swing and de-emphasis
  localparam int DSWING_LSB = 5;
  localparam int CSWING_LSB = 2;
  localparam int DEEMPH_LSB = 0;
  // Field positions, fixed equalizer levels
  localparam int RSVD_HI_LSB = 6;
  localparam int DEQ_LSB     = 3;
  localparam int CEQ_LSB     = 1;
  localparam int RSVD_LO_BIT = 0;

  // Reset values
  localparam logic       RST_PLACE  = 1'h0;
  localparam logic       RST_HPBLK  = 1'h0;
  localparam logic       RST_ADAPT  = 1'h1;
  localparam logic       RST_EQEN   = 1'h1;
  localparam logic       RST_RSV    = 1'h0;
  localparam logic [1:0] RST_MODE   = 2'h1;
  localparam logic [1:0] RST_SLEW   = 2'h0;
  localparam logic       RST_PROTO  = 1'h0;
  localparam logic [1:0] RST_TERM   = 2'h0;
  localparam logic [2:0] RST_SWING  = 3'h0;
  localparam logic [1:0] RST_DEEMPH = 2'h0;
  localparam logic [2:0] RST_DEQ    = 3'h0;
  localparam logic [1:0] RST_CEQ    = 2'h0;

  // Redriver / retimer function modes
  typedef enum logic [1:0] {
    MODE_REDRIVER = 2'h0,
    MODE_AUTO     = 2'h1,
    MODE_RSVD     = 2'h2,
    MODE_RETIMER  = 2'h3
  } lcr_func_mode_e;

  // Lane settings that pass through the staging stage
  typedef struct packed {
    logic [1:0] slew;
    logic [1:0] term;
    logic [1:0] deemph;
    logic       eqEn;
    logic       eqAdapt;
    logic [2:0] dataSwing;
    logic [2:0] clkSwing;
    logic [2:0] dataEq;
    logic [1:0] clkEq;
  } lcr_lane_cfg_s;

  localparam lcr_lane_cfg_s LANE_RST = '{
    slew: RST_SLEW, term: RST_TERM, deemph: RST_DEEMPH,
    eqEn: RST_EQEN, eqAdapt: RST_ADAPT, dataSwing: RST_SWING,
    clkSwing: RST_SWING, dataEq: RST_DEQ, clkEq: RST_CEQ};

  // One register access from the host engine
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } lcr_reg_req_s;

endpackage : lcr_pkg

// >>> testbench/lcr_host_model.sv
// Host side model: single-byte register accesses and power cycling.
// Assumes the bench calls its tasks; drives on the falling clock edge.
`timescale 1ns/1ns
module lcr_host_model (
  input  wire logic             clk,
  output lcr_pkg::lcr_reg_req_s regReq,
  output logic                  hostPowerDown
);
  // Idle port and powered-up state at time zero
  initial begin
    regReq        = '0;
    hostPowerDown = 1'b0;
  end

  // Byte write, strobe high for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(negedge clk);
    regReq <= '0;
  endtask : wr

  // Byte read request, answer collected by the bench monitor
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(negedge clk);
    regReq <= '0;
  endtask : rd

  // Byte write, then a read of the same offset in the next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(negedge clk);
    regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(negedge clk);
    regReq <= '0;
  endtask : wr_rd

  // Power off for two cycles, then on again, after a function mode change
  task automatic pwr_cycle();
    @(negedge clk);
    hostPowerDown <= 1'b1;
    repeat (2) @(negedge clk);
    hostPowerDown <= 1'b0;
  endtask : pwr_cycle
endmodule : lcr_host_model

// >>> testbench/link_conditioner_config_regs_tb_top.sv
// Self-checking bench for the configuration register bank.
// Assumes the host model drives the register port and power-down.
`timescale 1ns/1ns
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin \
  n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, \
  (act), (exp)); end end
module link_conditioner_config_regs_tb_top;
  logic                    clk;
  logic                    srst;
  logic                    strapCfgSel;
  logic                    outputEnable;
  logic                    sinkHotplugIn;
  logic                    hostPowerDown;
  logic                    sourceHotplugOut;
  logic                    sinkPlacement;
  logic                    outputProtocolAlt;
  logic                    regRdValid;
  logic [7:0]              regRdData;
  lcr_pkg::lcr_reg_req_s   regReq;
  lcr_pkg::lcr_func_mode_e functionMode;
  lcr_pkg::lcr_lane_cfg_s  laneCfg;
  lcr_pkg::lcr_lane_cfg_s  expCfg;
  logic [7:0]              expQ[$];
  logic [7:0]              b;
  logic [7:0]              s;
  logic [7:0]              d;
  int                      n_errors = 0;
  int                      compares = 0;

  lcr_host_model host (.clk(clk), .regReq(regReq),
                       .hostPowerDown(hostPowerDown));

  lcr_config_regs DUT (.clk(clk), .srst(srst), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .strapCfgSel(strapCfgSel), .outputEnable(outputEnable),
    .sinkHotplugIn(sinkHotplugIn), .hostPowerDown(hostPowerDown),
    .sourceHotplugOut(sourceHotplugOut), .sinkPlacement(sinkPlacement),
    .functionMode(functionMode), .outputProtocolAlt(outputProtocolAlt),
    .laneCfg(laneCfg));

  // Clock at 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Verdict and end of run
  task automatic stop_test();
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // Note the expected byte, then issue the read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask : rd

  // Note the written byte, then write and read back at once
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.wr_rd(a, e);
  endtask : wr_rd

  // Read answers against the oldest noted value
  always @(negedge clk) begin
    if (regRdValid === 1'b1) begin
      `CHK(expQ.size() > 0, 1'b1)
      if (expQ.size() > 0) begin
        `CHK(regRdData, expQ.pop_front())
      end
    end
  end

  // Watchdog against a hung run
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    srst          = 1'b1;
    strapCfgSel   = 1'b1;
    outputEnable  = 1'b1;
    sinkHotplugIn = 1'b1;
    void'($urandom(32'hba7e_ce59));
    repeat (10) @(negedge clk);
    srst = 1'b0;
    // Reset values
    `CHK(laneCfg, lcr_pkg::LANE_RST)
    `CHK(functionMode, lcr_pkg::MODE_AUTO)
    rd(lcr_pkg::ADDR_RX_MODE, 8'h31);
    rd(lcr_pkg::ADDR_DRIVER, 8'h00);
    rd(lcr_pkg::ADDR_SWING, 8'h00);
    rd(lcr_pkg::ADDR_EQ_LEV, 8'h00);
    rd(8'h0E, 8'h00);
    // Staged lane fields with the link active
    b = 8'($urandom());
    s = 8'($urandom());
    d = 8'($urandom());
    host.wr(lcr_pkg::ADDR_DRIVER, b);
    `CHK(outputProtocolAlt, b[5])
    wr_rd(lcr_pkg::ADDR_SWING, s);
    wr_rd(lcr_pkg::ADDR_EQ_LEV, d);
    `CHK(laneCfg, lcr_pkg::LANE_RST)
    rd(lcr_pkg::ADDR_DRIVER, b & 8'hF8);
    rd(lcr_pkg::ADDR_SWING, s);
    rd(lcr_pkg::ADDR_EQ_LEV, d);
    host.wr(lcr_pkg::ADDR_RX_MODE, 8'h25);
    expCfg = '{slew: b[7:6], term: b[4:3], deemph: s[1:0], eqEn: 1'b0,
               eqAdapt: 1'b1, dataSwing: s[7:5], clkSwing: s[4:2],
               dataEq: d[5:3], clkEq: d[2:1]};
    `CHK(laneCfg, expCfg)
    rd(lcr_pkg::ADDR_RX_MODE, 8'h21);
    // Pin mode blocks strap-owned fields
    strapCfgSel = 1'b0;
    host.wr(lcr_pkg::ADDR_DRIVER, 8'hE7);
    `CHK(outputProtocolAlt, b[5])
    rd(lcr_pkg::ADDR_DRIVER, b & 8'hE0);
    host.wr(lcr_pkg::ADDR_RX_MODE, 8'h11);
    rd(lcr_pkg::ADDR_RX_MODE, 8'h31);
    strapCfgSel = 1'b1;
    // Output disabled loads settings without apply
    outputEnable = 1'b0;
    host.wr(lcr_pkg::ADDR_SWING, 8'hE0);
    `CHK(laneCfg.dataSwing, 3'h7)
    `CHK(laneCfg.clkSwing, 3'h0)
    outputEnable = 1'b1;
    // Hot-plug forwarding and blocking
    `CHK(sourceHotplugOut, 1'b1)
    sinkHotplugIn = 1'b0;
    @(negedge clk);
    `CHK(sourceHotplugOut, 1'b0)
    sinkHotplugIn = 1'b1;
    @(negedge clk);
    `CHK(sourceHotplugOut, 1'b1)
    host.wr(lcr_pkg::ADDR_RX_MODE, 8'h71);
    @(negedge clk);
    `CHK(sourceHotplugOut, 1'b0)
    // Placement and every function mode
    host.wr(lcr_pkg::ADDR_RX_MODE, 8'hB1);
    `CHK(sinkPlacement, 1'b1)
    for (int m = 0; m < 4; m++) begin
      host.wr(lcr_pkg::ADDR_RX_MODE, {6'h0C, 2'(m)});
      host.pwr_cycle();
      `CHK(functionMode, lcr_pkg::lcr_func_mode_e'(m))
      `CHK(sinkPlacement, 1'b0)
    end
    // Drain outstanding reads
    for (int i = 0; i < 8 && expQ.size() > 0; i++) begin
      @(negedge clk);
    end
    `CHK(expQ.size() == 0, 1'b1)
    stop_test();
  end
endmodule : link_conditioner_config_regs_tb_top
